// ==== shared/dof_link_if.sv ====
`default_nettype none
interface dof_link_if;
  import dof_pkg::*;
  dof_size_t   size;
  logic [31:0] addr;
  logic        stack;
  logic        little;
  logic [31:0] rdata;
  logic [31:0] load_data;
  logic        addr_err;
  dof_imm_t    imm_class;
  logic [7:0]  imm_byte;
  logic [31:0] pc;
  logic [31:0] imm_value;
  logic        fetch;
  logic [31:0] fetch_addr;
  dof_size_t   fetch_size;

  modport core  (output size, addr, stack, little, rdata, imm_class, imm_byte, pc,
                 input load_data, addr_err, imm_value, fetch, fetch_addr, fetch_size);
  modport align (input size, addr, stack, little, rdata, output load_data, addr_err);
  modport imm   (input imm_class, imm_byte, pc,
                 output imm_value, fetch, fetch_addr, fetch_size);
endinterface
`default_nettype wire

// ==== shared/dof_pkg.sv ====
`default_nettype none
package dof_pkg;

  localparam int DATA_W       = 32;
  localparam int ACC_W        = 40;
  localparam int GUARD_W      = 8;
  localparam int GUARD_LSB    = 32;
  localparam int HALF_LSB     = 16;
  localparam int NUM_ACC      = 2;
  localparam int NUM_GEN      = 6;
  localparam int GEN_BASE     = 4;
  localparam int FLAG_GT      = 3;
  localparam int FLAG_Z       = 2;
  localparam int FLAG_N       = 1;
  localparam int FLAG_V       = 0;
  localparam int SHIFT_A_MIN  = -32;
  localparam int SHIFT_A_MAX  = 32;
  localparam int SHIFT_L_MIN  = -16;
  localparam int SHIFT_L_MAX  = 16;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [31:0] GEN_RST = 32'h0000_0000;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} dof_size_t;

  typedef enum logic [3:0] {
    IMM_MOV, IMM_ADD, IMM_CMPEQ, IMM_TST, IMM_AND, IMM_OR, IMM_XOR,
    IMM_WORD_TABLE, IMM_LONG_TABLE
  } dof_imm_t;

  typedef enum logic [1:0] {FMT_FIXED, FMT_INTEGER, FMT_LOGIC} dof_fmt_t;

  typedef enum logic [2:0] {
    DI_GENERIC, DI_ARITHMETIC_SHIFT, DI_LOGICAL_SHIFT, DI_SIGNED_MULTIPLY, DI_MSB_DETECT
  } dof_dinstr_t;

  typedef enum logic [3:0] {
    ACCUMULATOR_FIRST, ACCUMULATOR_SECOND, GUARD_REG_FIRST, GUARD_REG_SECOND,
    X_INPUT_REG_FIRST, X_INPUT_REG_SECOND, Y_INPUT_REG_FIRST, Y_INPUT_REG_SECOND,
    MULTIPLIER_REG_FIRST, MULTIPLIER_REG_SECOND
  } dof_reg_t;

  function automatic logic [31:0] sext8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic dof_fmt_t src_fmt(input dof_fmt_t f, input dof_dinstr_t i);
    case (i)
      DI_ARITHMETIC_SHIFT, DI_MSB_DETECT:   return FMT_FIXED;
      DI_LOGICAL_SHIFT, DI_SIGNED_MULTIPLY: return FMT_LOGIC;
      default:                              return f;
    endcase
  endfunction

  function automatic dof_fmt_t dst_fmt(input dof_fmt_t f, input dof_dinstr_t i);
    case (i)
      DI_ARITHMETIC_SHIFT, DI_SIGNED_MULTIPLY: return FMT_FIXED;
      DI_MSB_DETECT:                           return FMT_INTEGER;
      DI_LOGICAL_SHIFT:                        return FMT_LOGIC;
      default:                                 return f;
    endcase
  endfunction

endpackage
`default_nettype wire

// ==== test/dof_format_unit_tb.sv ====
`default_nettype none
module dof_format_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dof_pkg::*;
  typedef struct packed {dof_size_t sz; logic [31:0] a; logic [2:0] f; logic [31:0] d;} dof_mrow_t;
  logic sys_clk_i = 0, rstn_i = 0, mem_req_i = 0, mem_stack_i = 0, little_endian_i = 0;
  logic imm_req_i = 0, op_req_i = 0, res_we_i = 0, xy_load_i = 0, xy_store_i = 0;
  logic sx_load_i = 0, sx_store_i = 0, sx_long_i = 0;
  logic [31:0] mem_addr_i = 0, mem_rdata_i, pc_i = 0, sx_data_i = 0;
  logic [7:0] imm_byte_i = 0;
  logic [15:0] xy_data_i = 0, xy_data_o;
  logic [39:0] res_i = 0, operand_o;
  dof_size_t mem_size_i = SIZE_BYTE, imm_fetch_size_o;
  dof_imm_t imm_class_i = IMM_MOV;
  dof_fmt_t op_fmt_i = FMT_FIXED, res_fmt_i = FMT_FIXED;
  dof_dinstr_t op_instr_i = DI_GENERIC, res_instr_i = DI_GENERIC;
  dof_reg_t src_sel_i = ACCUMULATOR_FIRST, sa_sel_i = ACCUMULATOR_FIRST;
  dof_reg_t res_dst_i = ACCUMULATOR_FIRST, xy_reg_i = ACCUMULATOR_FIRST;
  dof_reg_t sx_reg_i = ACCUMULATOR_FIRST;
  logic gpr_we_o, addr_err_o, imm_valid_o, imm_fetch_o, op_valid_o, src_illegal_o, shift_ok_o;
  logic [31:0] gpr_wdata_o, imm_value_o, imm_fetch_addr_o, sx_data_o;
  logic [6:0] shift_amt_o;
  logic [3:0] flags_o;
  int n_errors = 0, compares = 0, cyc = 0;
  dof_mrow_t mrow [11];
  always #25 sys_clk_i = ~sys_clk_i;
  dof_mem_model u_dof_mem_model (.sys_clk_i, .req_i(mem_req_i), .addr_i(mem_addr_i),
    .rdata_o(mem_rdata_i));
  dof_format_unit u_dof_format_unit (.sys_clk_i, .rstn_i, .mem_req_i, .mem_size_i,
    .mem_addr_i, .mem_stack_i, .mem_rdata_i, .little_endian_i, .gpr_we_o, .gpr_wdata_o,
    .addr_err_o, .imm_req_i, .imm_class_i, .imm_byte_i, .pc_i, .imm_valid_o, .imm_value_o,
    .imm_fetch_o, .imm_fetch_addr_o, .imm_fetch_size_o, .op_req_i, .op_fmt_i, .op_instr_i,
    .src_sel_i, .sa_sel_i, .op_valid_o, .operand_o, .src_illegal_o, .shift_amt_o,
    .shift_ok_o, .res_we_i, .res_dst_i, .res_fmt_i, .res_instr_i, .res_i, .flags_o,
    .xy_load_i, .xy_store_i, .xy_reg_i, .xy_data_i, .xy_data_o, .sx_load_i, .sx_store_i,
    .sx_long_i, .sx_reg_i, .sx_data_i, .sx_data_o);
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a hang is cut short well past the hundred or so cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run;
    end
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step;
    @(negedge sys_clk_i);
  endtask
  // one request pulse; an idle cycle sits between pulses so no strobe is set twice at once
  task automatic fire(input logic [7:0] v);
    step;
    {mem_req_i, imm_req_i, op_req_i, res_we_i, xy_load_i, xy_store_i, sx_load_i, sx_store_i} = v;
    step;
    {mem_req_i, imm_req_i, op_req_i, res_we_i, xy_load_i, xy_store_i, sx_load_i, sx_store_i} = 8'h00;
  endtask
  task automatic op(input dof_fmt_t f, input dof_dinstr_t i, input dof_reg_t s, a);
    op_fmt_i = f;
    op_instr_i = i;
    src_sel_i = s;
    sa_sel_i = a;
    fire(8'h20);
  endtask
  task automatic sx(input logic [1:0] ls, input logic g, input dof_reg_t r, input logic [31:0] d);
    sx_long_i = g;
    sx_reg_i = r;
    sx_data_i = d;
    fire({6'h00, ls});
  endtask
  initial begin
    mrow = '{'{SIZE_BYTE, 32'h0, 3'h0, 32'hFFFF_FF80}, '{SIZE_BYTE, 32'h1, 3'h0, 32'h0000_007F},
      '{SIZE_BYTE, 32'h3, 3'h2, 32'h0000_0034}, '{SIZE_WORD, 32'h0, 3'h0, 32'hFFFF_807F},
      '{SIZE_WORD, 32'h2, 3'h2, 32'h0000_3412}, '{SIZE_WORD, 32'h1, 3'h1, 32'h0},
      '{SIZE_LONG, 32'h0, 3'h0, 32'h807F_1234}, '{SIZE_LONG, 32'h2, 3'h1, 32'h0},
      '{SIZE_LONG, 32'h4, 3'h2, 32'h6745_2301}, '{SIZE_WORD, 32'h4, 3'h5, 32'h0},
      '{SIZE_LONG, 32'h4, 3'h4, 32'h0123_4567}};
    repeat (4) step;
    chk({gpr_we_o, addr_err_o, imm_valid_o, imm_fetch_o, op_valid_o, flags_o}, 40'h0);
    chk(imm_fetch_size_o, SIZE_LONG);
    rstn_i = 1;
    foreach (mrow[k]) begin
      mem_size_i = mrow[k].sz;
      mem_addr_i = mrow[k].a;
      {mem_stack_i, little_endian_i} = mrow[k].f[2:1];
      fire(8'h80);
      chk(addr_err_o, mrow[k].f[0]);
      chk(gpr_we_o, !mrow[k].f[0]);
      if (!mrow[k].f[0]) chk(gpr_wdata_o, mrow[k].d);
    end
    for (int c = 0; c < 9; c++) begin
      imm_class_i = dof_imm_t'(c);
      imm_byte_i = 8'h83;
      pc_i = 32'h0000_0102;
      fire(8'h40);
      chk(imm_valid_o, c < 7);
      chk(imm_fetch_o, c > 6);
      if (c < 3) chk(imm_value_o, 32'hFFFF_FF83);
      else if (c < 7) chk(imm_value_o, 32'h0000_0083);
      else begin
        chk(imm_fetch_o, 1'h1);
        chk(imm_fetch_addr_o, c == 7 ? 32'h0000_0208 : 32'h0000_030C);
        chk(imm_fetch_size_o, c == 7 ? SIZE_WORD : SIZE_LONG);
      end
    end
    sx(2'h2, 1'h1, X_INPUT_REG_FIRST, 32'h8000_1234);
    op(FMT_FIXED, DI_GENERIC, X_INPUT_REG_FIRST, X_INPUT_REG_FIRST);
    chk(operand_o, 40'hFF_8000_1234);
    op(FMT_INTEGER, DI_GENERIC, X_INPUT_REG_FIRST, X_INPUT_REG_FIRST);
    chk(operand_o, 40'hFF_8000_0000);
    op(FMT_LOGIC, DI_GENERIC, X_INPUT_REG_FIRST, X_INPUT_REG_FIRST);
    chk(operand_o, 40'h00_8000_0000);
    sx(2'h2, 1'h1, ACCUMULATOR_FIRST, 32'h1234_5678);
    sx(2'h2, 1'h0, GUARD_REG_FIRST, 32'h0000_0085);
    op(FMT_FIXED, DI_GENERIC, ACCUMULATOR_FIRST, X_INPUT_REG_FIRST);
    chk(operand_o, 40'h85_1234_5678);
    sx(2'h1, 1'h0, GUARD_REG_FIRST, 32'h0);
    chk(sx_data_o, 32'hFFFF_FF85);
    sx(2'h1, 1'h0, ACCUMULATOR_FIRST, 32'h0);
    chk(sx_data_o, 32'h0000_1234);
    sx(2'h1, 1'h1, ACCUMULATOR_FIRST, 32'h0);
    chk(sx_data_o, 32'h1234_5678);
    op(FMT_FIXED, DI_SIGNED_MULTIPLY, ACCUMULATOR_FIRST, X_INPUT_REG_FIRST);
    chk(src_illegal_o, 1'h1);
    op(FMT_FIXED, DI_SIGNED_MULTIPLY, ACCUMULATOR_SECOND, X_INPUT_REG_FIRST);
    chk(src_illegal_o, 1'h0);
    xy_reg_i = X_INPUT_REG_SECOND;
    xy_data_i = 16'hABCD;
    fire(8'h08);
    fire(8'h04);
    chk(xy_data_o, 16'hABCD);
    op(FMT_FIXED, DI_ARITHMETIC_SHIFT, X_INPUT_REG_SECOND, X_INPUT_REG_SECOND);
    chk(operand_o, 40'hFF_ABCD_0000);
    chk({shift_amt_o, shift_ok_o}, {7'h4D, 1'h0});
    op(FMT_FIXED, DI_LOGICAL_SHIFT, X_INPUT_REG_FIRST, X_INPUT_REG_SECOND);
    chk({shift_amt_o, shift_ok_o}, {7'h0D, 1'h1});
    res_dst_i = X_INPUT_REG_FIRST;
    res_i = 40'h01_0000_0000;
    fire(8'h10);
    chk(flags_o, 4'h9);
    op(FMT_FIXED, DI_GENERIC, X_INPUT_REG_FIRST, X_INPUT_REG_FIRST);
    chk(operand_o, 40'h0);
    res_dst_i = ACCUMULATOR_SECOND;
    res_instr_i = DI_MSB_DETECT;
    res_i = 40'hFF_8000_1234;
    fire(8'h10);
    chk(flags_o, 4'h2);
    op(FMT_FIXED, DI_GENERIC, ACCUMULATOR_SECOND, X_INPUT_REG_FIRST);
    chk(operand_o, 40'hFF_8000_0000);
    chk(op_valid_o, 1'h1);
    step;
    rstn_i = 0;
    step;
    rstn_i = 1;
    chk({gpr_we_o, addr_err_o, imm_valid_o, imm_fetch_o, op_valid_o, flags_o}, 40'h0);
    op(FMT_FIXED, DI_GENERIC, ACCUMULATOR_FIRST, X_INPUT_REG_FIRST);
    chk(operand_o, 40'h0);
    complete_run;
  end
endmodule
`default_nettype wire

// ==== test/dof_mem_model.sv ====
`default_nettype none
module dof_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] last;
  // two aligned words, lane 0 in bits 31:24
  always_comb begin
    if (req_i) rdata_o = addr_i[2] ? 32'h0123_4567 : 32'h807F_1234;
    else rdata_o = ~last;
  end
  // idle bus toggles so stale data cannot pass for a real read
  always_ff @(posedge sys_clk_i) last <= rdata_o;
endmodule
`default_nettype wire

// ==== verilog/dof_format_unit.sv ====
`default_nettype none
module dof_format_unit (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 mem_req_i,
  input  wire dof_pkg::dof_size_t   mem_size_i,
  input  wire logic [31:0]          mem_addr_i,
  input  wire logic                 mem_stack_i,
  input  wire logic [31:0]          mem_rdata_i,
  input  wire logic                 little_endian_i,
  output logic                      gpr_we_o,
  output logic [31:0]               gpr_wdata_o,
  output logic                      addr_err_o,
  input  wire logic                 imm_req_i,
  input  wire dof_pkg::dof_imm_t    imm_class_i,
  input  wire logic [7:0]           imm_byte_i,
  input  wire logic [31:0]          pc_i,
  output logic                      imm_valid_o,
  output logic [31:0]               imm_value_o,
  output logic                      imm_fetch_o,
  output logic [31:0]               imm_fetch_addr_o,
  output dof_pkg::dof_size_t        imm_fetch_size_o,
  input  wire logic                 op_req_i,
  input  wire dof_pkg::dof_fmt_t    op_fmt_i,
  input  wire dof_pkg::dof_dinstr_t op_instr_i,
  input  wire dof_pkg::dof_reg_t    src_sel_i,
  input  wire dof_pkg::dof_reg_t    sa_sel_i,
  output logic                      op_valid_o,
  output logic [39:0]               operand_o,
  output logic                      src_illegal_o,
  output logic [6:0]                shift_amt_o,
  output logic                      shift_ok_o,
  input  wire logic                 res_we_i,
  input  wire dof_pkg::dof_reg_t    res_dst_i,
  input  wire dof_pkg::dof_fmt_t    res_fmt_i,
  input  wire dof_pkg::dof_dinstr_t res_instr_i,
  input  wire logic [39:0]          res_i,
  output logic [3:0]                flags_o,
  input  wire logic                 xy_load_i,
  input  wire logic                 xy_store_i,
  input  wire dof_pkg::dof_reg_t    xy_reg_i,
  input  wire logic [15:0]          xy_data_i,
  output logic [15:0]               xy_data_o,
  input  wire logic                 sx_load_i,
  input  wire logic                 sx_store_i,
  input  wire logic                 sx_long_i,
  input  wire dof_pkg::dof_reg_t    sx_reg_i,
  input  wire logic [31:0]          sx_data_i,
  output logic [31:0]               sx_data_o
);
  import dof_pkg::*;

  // 40-bit accumulators with guard byte in 39:32, 32-bit input/multiplier regs
  logic [39:0] acc [NUM_ACC];
  logic [31:0] gen [NUM_GEN];
  dof_link_if  lnk ();

  assign lnk.size      = mem_size_i;
  assign lnk.addr      = mem_addr_i;
  assign lnk.stack     = mem_stack_i;
  assign lnk.little    = little_endian_i;
  assign lnk.rdata     = mem_rdata_i;
  assign lnk.imm_class = imm_class_i;
  assign lnk.imm_byte  = imm_byte_i;
  assign lnk.pc        = pc_i;

  dof_mem_align u_align (
    .lnk (lnk)
  );

  dof_imm_ext u_imm (
    .lnk (lnk)
  );

  function automatic logic [2:0] gen_idx(input dof_reg_t sel);
    return 3'(4'(sel) - 4'(GEN_BASE));
  endfunction

  function automatic logic is_acc(input dof_reg_t sel);
    return sel == ACCUMULATOR_FIRST || sel == ACCUMULATOR_SECOND;
  endfunction

  function automatic logic is_guard(input dof_reg_t sel);
    return sel == GUARD_REG_FIRST || sel == GUARD_REG_SECOND;
  endfunction

  // fixed: point between 31/30; integer: point between 16/15
  function automatic logic [39:0] read_src(input dof_reg_t sel, input dof_fmt_t f);
    logic [39:0] raw;
    raw = '0;
    if (is_acc(sel)) begin
      raw = acc[sel[0]];
    end else if (!is_guard(sel)) begin
      raw = {{GUARD_W{gen[gen_idx(sel)][31]}}, gen[gen_idx(sel)]};
    end
    case (f)
      FMT_FIXED:   return raw;
      FMT_INTEGER: return {raw[39:16], 16'h0000};
      FMT_LOGIC:   return {8'h00, raw[31:16], 16'h0000};
      default:     return raw;
    endcase
  endfunction

  function automatic logic [39:0] shape_dst(input logic [39:0] r, input dof_fmt_t f);
    case (f)
      FMT_FIXED:   return r;
      FMT_INTEGER: return {r[39:16], 16'h0000};
      FMT_LOGIC:   return {8'h00, r[31:16], 16'h0000};
      default:     return r;
    endcase
  endfunction

  function automatic logic src_legal(input dof_reg_t sel, input dof_dinstr_t i);
    if (is_guard(sel)) begin
      return 1'b0;
    end
    return !(i == DI_SIGNED_MULTIPLY && sel == ACCUMULATOR_FIRST);
  endfunction

  // upper word of a register, as the 16-bit buses carry it
  function automatic logic [15:0] upper_word(input dof_reg_t sel);
    if (is_acc(sel)) begin
      return acc[sel[0]][31:16];
    end
    return is_guard(sel) ? 16'h0000 : gen[gen_idx(sel)][31:16];
  endfunction

  dof_fmt_t    res_df;
  logic [39:0] res_shaped;
  logic [39:0] sa_word;
  logic [6:0]  sa_logic;

  assign res_df     = dst_fmt(res_fmt_i, res_instr_i);
  assign res_shaped = shape_dst(res_i, res_df);
  // a process, not an assign: it must also wake when the register file changes
  always_comb begin
    sa_word  = read_src(sa_sel_i, FMT_INTEGER);
    sa_logic = {sa_word[21], sa_word[21:16]};
  end

  // one write port per cycle: result beats single transfer beats x/y load
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc[i] <= ACC_RST;
      end
      for (int i = 0; i < NUM_GEN; i++) begin
        gen[i] <= GEN_RST;
      end
    end else if (res_we_i && !is_guard(res_dst_i)) begin
      if (is_acc(res_dst_i)) begin
        acc[res_dst_i[0]] <= res_shaped;
      end else begin
        gen[gen_idx(res_dst_i)] <= res_shaped[31:0];
      end
    end else if (sx_load_i) begin
      if (is_guard(sx_reg_i)) begin
        acc[sx_reg_i[0]][39:32] <= sx_data_i[7:0];
      end else if (is_acc(sx_reg_i)) begin
        acc[sx_reg_i[0]] <= sx_long_i ? {{GUARD_W{sx_data_i[31]}}, sx_data_i}
                                      : {{GUARD_W{sx_data_i[15]}}, sx_data_i[15:0], 16'h0000};
      end else begin
        gen[gen_idx(sx_reg_i)] <= sx_long_i ? sx_data_i : {sx_data_i[15:0], 16'h0000};
      end
    end else if (xy_load_i && !is_guard(xy_reg_i)) begin
      if (is_acc(xy_reg_i)) begin
        acc[xy_reg_i[0]] <= {{GUARD_W{xy_data_i[15]}}, xy_data_i, 16'h0000};
      end else begin
        gen[gen_idx(xy_reg_i)] <= {xy_data_i, 16'h0000};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gpr_we_o    <= 1'b0;
      gpr_wdata_o <= '0;
      addr_err_o  <= 1'b0;
    end else begin
      // data behind a failed alignment is not trusted, so no write is issued
      gpr_we_o    <= mem_req_i && !lnk.addr_err;
      gpr_wdata_o <= mem_req_i ? lnk.load_data : gpr_wdata_o;
      addr_err_o  <= mem_req_i && lnk.addr_err;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      imm_valid_o      <= 1'b0;
      imm_value_o      <= '0;
      imm_fetch_o      <= 1'b0;
      imm_fetch_addr_o <= '0;
      imm_fetch_size_o <= SIZE_LONG;
    end else begin
      imm_valid_o      <= imm_req_i && !lnk.fetch;
      imm_fetch_o      <= imm_req_i && lnk.fetch;
      if (imm_req_i) begin
        imm_value_o      <= lnk.imm_value;
        imm_fetch_addr_o <= lnk.fetch_addr;
        imm_fetch_size_o <= lnk.fetch_size;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      op_valid_o    <= 1'b0;
      operand_o     <= '0;
      src_illegal_o <= 1'b0;
      shift_amt_o   <= '0;
      shift_ok_o    <= 1'b0;
    end else begin
      op_valid_o    <= op_req_i;
      src_illegal_o <= op_req_i && !src_legal(src_sel_i, op_instr_i);
      if (op_req_i) begin
        operand_o <= read_src(src_sel_i, src_fmt(op_fmt_i, op_instr_i));
        case (op_instr_i)
          DI_ARITHMETIC_SHIFT: begin
            shift_amt_o <= sa_word[22:16];
            shift_ok_o  <= int'($signed(sa_word[22:16])) >= SHIFT_A_MIN &&
                           int'($signed(sa_word[22:16])) <= SHIFT_A_MAX;
          end
          DI_LOGICAL_SHIFT: begin
            shift_amt_o <= sa_logic;
            shift_ok_o  <= int'($signed(sa_logic)) >= SHIFT_L_MIN &&
                           int'($signed(sa_logic)) <= SHIFT_L_MAX;
          end
          default: begin
            shift_amt_o <= '0;
            shift_ok_o  <= 1'b0;
          end
        endcase
      end else begin
        shift_ok_o <= 1'b0;
      end
    end
  end

  // flags look at the full 40-bit value even for a 32-bit destination
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      flags_o <= '0;
    end else if (res_we_i) begin
      flags_o[FLAG_Z]  <= (res_shaped == '0);
      flags_o[FLAG_N]  <= res_shaped[39];
      flags_o[FLAG_V]  <= !(&res_shaped[39:31] || !(|res_shaped[39:31]));
      flags_o[FLAG_GT] <= !res_shaped[39] && (res_shaped != '0);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      xy_data_o <= '0;
      sx_data_o <= '0;
    end else begin
      if (xy_store_i) begin
        xy_data_o <= upper_word(xy_reg_i);
      end
      if (sx_store_i) begin
        if (is_guard(sx_reg_i)) begin
          sx_data_o <= sext8(acc[sx_reg_i[0]][39:32]);
        end else if (sx_long_i) begin
          sx_data_o <= is_acc(sx_reg_i) ? acc[sx_reg_i[0]][31:0]
                                        : gen[gen_idx(sx_reg_i)];
        end else begin
          sx_data_o <= sext16(upper_word(sx_reg_i));
        end
      end
    end
  end

  a_load_sign: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mem_req_i && mem_size_i == SIZE_BYTE && !mem_stack_i
      |=> gpr_we_o && (gpr_wdata_o[31:7] == '0 || &gpr_wdata_o[31:7]))
    else $error("byte load not sign-extended");
  a_word_align: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mem_req_i && mem_size_i == SIZE_WORD && mem_addr_i[0] |=> addr_err_o && !gpr_we_o)
    else $error("odd word access not flagged");
  a_stack_long: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mem_req_i && mem_stack_i && mem_size_i != SIZE_LONG |=> addr_err_o)
    else $error("short stack access not flagged");
  a_imm_sign: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    imm_req_i && imm_class_i == IMM_ADD && imm_byte_i[7] |=> &imm_value_o[31:8])
    else $error("add immediate not sign-extended");
  a_imm_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    imm_req_i && imm_class_i == IMM_AND |=> imm_value_o[31:8] == '0 && imm_valid_o)
    else $error("and immediate not zero-extended");
  a_imm_table: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    imm_req_i && imm_class_i == IMM_WORD_TABLE
      |=> imm_fetch_o && !imm_valid_o && imm_fetch_size_o == SIZE_WORD)
    else $error("word immediate not fetched");
  a_src_guard: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    op_req_i && op_instr_i == DI_GENERIC && op_fmt_i == FMT_FIXED && !is_acc(src_sel_i)
      |=> operand_o[39:32] == {8{operand_o[31]}})
    else $error("source guard not sign-extended");
  a_int_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    op_req_i && op_instr_i == DI_GENERIC && op_fmt_i == FMT_INTEGER |=> operand_o[15:0] == '0)
    else $error("integer source low word not ignored");
  a_logic_src: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    op_req_i && op_instr_i == DI_LOGICAL_SHIFT
      |=> operand_o[39:32] == '0 && operand_o[15:0] == '0)
    else $error("logical source not upper word");
  a_arithmetic_shift_instr_range: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    op_req_i && op_instr_i == DI_ARITHMETIC_SHIFT |=>
      shift_ok_o == ($signed(shift_amt_o) >= -7'sd32 && $signed(shift_amt_o) <= 7'sd32))
    else $error("arithmetic shift range wrong");
  a_mul_src: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    op_req_i && op_instr_i == DI_SIGNED_MULTIPLY && src_sel_i == ACCUMULATOR_FIRST
      |=> src_illegal_o)
    else $error("illegal multiply source accepted");
  a_guard_keep: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sx_load_i && !res_we_i && sx_reg_i == GUARD_REG_FIRST
      |=> acc[0][31:0] == $past(acc[0][31:0]) && acc[0][39:32] == $past(sx_data_i[7:0]))
    else $error("guard load disturbed accumulator");
  a_flag_over: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    res_we_i && res_instr_i == DI_GENERIC && res_fmt_i == FMT_FIXED
      |=> flags_o[FLAG_V] == ($past(res_i[39:31]) != '0 && $past(res_i[39:31]) != '1))
    else $error("overflow flag ignores guard bits");

  c_misaligned: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) addr_err_o);
  c_table_fetch: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) imm_fetch_o);
  c_guard_store: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sx_store_i && is_guard(sx_reg_i));
  c_shift_bad: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    op_req_i && op_instr_i == DI_ARITHMETIC_SHIFT ##1 !shift_ok_o);
endmodule
`default_nettype wire

// ==== verilog/dof_imm_ext.sv ====
`default_nettype none
module dof_imm_ext (
  dof_link_if.imm lnk
);
  import dof_pkg::*;

  always_comb begin
    lnk.imm_value  = '0;
    lnk.fetch      = 1'b0;
    lnk.fetch_addr = '0;
    lnk.fetch_size = SIZE_LONG;
    case (lnk.imm_class)
      IMM_MOV, IMM_ADD, IMM_CMPEQ: begin
        lnk.imm_value = sext8(lnk.imm_byte);
      end
      IMM_TST, IMM_AND, IMM_OR, IMM_XOR: begin
        lnk.imm_value = {24'h00_0000, lnk.imm_byte};
      end
      IMM_WORD_TABLE: begin
        lnk.fetch      = 1'b1;
        lnk.fetch_size = SIZE_WORD;
        lnk.fetch_addr = lnk.pc + {23'h00_0000, lnk.imm_byte, 1'b0};
      end
      IMM_LONG_TABLE: begin
        lnk.fetch      = 1'b1;
        lnk.fetch_addr = {lnk.pc[31:2], 2'h0} + {22'h00_0000, lnk.imm_byte, 2'h0};
      end
      default: begin
        lnk.imm_value = '0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== verilog/dof_mem_align.sv ====
`default_nettype none
module dof_mem_align (
  dof_link_if.align lnk
);
  import dof_pkg::*;

  logic [7:0] lane [4];
  logic [1:0] ofs;

  // lane 0 is the byte at the lowest address of the fetched word
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane[i] = lnk.rdata[31 - 8 * i -: 8];
    end
    ofs           = lnk.addr[1:0];
    lnk.addr_err  = 1'b0;
    lnk.load_data = '0;
    case (lnk.size)
      SIZE_BYTE: begin
        lnk.load_data = sext8(lane[ofs]);
      end
      SIZE_WORD: begin
        lnk.addr_err  = ofs[0];
        lnk.load_data = lnk.little ? sext16({lane[{ofs[1], 1'b1}], lane[{ofs[1], 1'b0}]})
                                   : sext16({lane[{ofs[1], 1'b0}], lane[{ofs[1], 1'b1}]});
      end
      SIZE_LONG: begin
        lnk.addr_err  = (ofs != 2'h0);
        lnk.load_data = lnk.little ? {lane[3], lane[2], lane[1], lane[0]} : lnk.rdata;
      end
      default: begin
        lnk.addr_err = 1'b1;
      end
    endcase
    // the stack holds pc and status words, so only aligned longwords are legal
    if (lnk.stack && lnk.size != SIZE_LONG) begin
      lnk.addr_err = 1'b1;
    end
  end
endmodule
`default_nettype wire
